// ==== rtl/esn_defs.vh ====
`ifndef ESN_DEFS_VH
`define ESN_DEFS_VH

// --------------------------------------------
// Snapshot indices (byte address = 4 * index)
// --------------------------------------------
`define ESN_IDX_CRC4_LO    8'h00
`define ESN_IDX_CRC4_HI    8'h01
`define ESN_IDX_FRAME_LO   8'h02
`define ESN_IDX_FRAME_HI   8'h03
`define ESN_IDX_ALIGN      8'h04
`define ESN_IDX_SYNC       8'h05
`define ESN_IDX_PATT_LO    8'h06
`define ESN_IDX_PATT_HI    8'h07
`define ESN_IDX_LCODE_LO   8'h08
`define ESN_IDX_LCODE_HI   8'h09
`define ESN_IDX_NTCRC_LO   8'h0a
`define ESN_IDX_NTCRC_HI   8'h0b
`define ESN_IDX_FAR_END_ERROR_COUNT_LO    8'h0c
`define ESN_IDX_FAR_END_ERROR_COUNT_HI    8'h0d
`define ESN_IDX_NTFEBE_LO  8'h0e
`define ESN_IDX_NTFEBE_HI  8'h0f
`define ESN_IDX_CTRL       8'h10
`define ESN_IDX_STAT       8'h11

// --------------------------------------------
// Control fields and reset value
// --------------------------------------------
`define ESN_CTRL_AUTO_BIT  0
`define ESN_CTRL_TRIG_BIT  1
`define ESN_CTRL_HDB3_BIT  2
`define ESN_CTRL_RESET     3'h0

// --------------------------------------------
// Counter maxima (all-ones of each width)
// --------------------------------------------
`define ESN_MAX_10         16'h03ff
`define ESN_MAX_12         16'h0fff
`define ESN_MAX_3          16'h0007
`define ESN_MAX_5          16'h001f
`define ESN_MAX_16         16'hffff

// --------------------------------------------
// Timing
// --------------------------------------------
`define ESN_CLK_KHZ        125000
`define ESN_SNAP_PERIOD_MS 1000
`define ESN_SNAP_PERIOD_CYC (`ESN_SNAP_PERIOD_MS * `ESN_CLK_KHZ)

`endif

// ==== rtl/esn_error_snapshot.v ====
// Notes on behaviour
// - All snapshot registers are loaded together in one clock cycle.
// - A zero-to-one change of the snapshot trigger bit loads every snapshot register.
// - With auto snapshot enabled, all snapshot registers are loaded once per second.
// - The CRC-4 error count is 10 bits, low byte at 00h, top bits at 01h bits 5:4.
// - The frame error count is 12 bits, low byte at 02h, top bits at 03h bits 3:0.
// - A 3-bit count at 04h bits 2:0 counts alignment position changes.
// - A 5-bit count at 05h bits 4:0 counts losses of frame synchronisation.
// - The pattern detector error count is 16 bits at 06h (low) and 07h (high).
// - The 16-bit line code count tallies bipolar violations in AMI, code violations in HDB3.
// - The NT CRC error count is 10 bits, low byte at 0Ah, top bits at 0Bh bits 5:4.
// - The far-end block error count is 10 bits, low byte at 0Ch, top bits at 0Dh bits 5:4.
// - The NT far-end block error count is 10 bits, low at 0Eh, top bits at 0Fh bits 5:4.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "esn_defs.vh"

module esn_error_snapshot
#(
   parameter SNAP_PERIOD_CYC = `ESN_SNAP_PERIOD_CYC
)
(
   // Clock and reset
   input  wire        clk_sys,
   input  wire        srst,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output wire [31:0] hrdata,
   // Receive error events, one-cycle pulses
   input  wire        crc4_err_evt,
   input  wire        frame_err_evt,
   input  wire        align_change_evt,
   input  wire        sync_loss_evt,
   input  wire        pattern_err_evt,
   input  wire        bipolar_viol_evt,
   input  wire        code_viol_evt,
   input  wire        nt_crc_err_evt,
   input  wire        far_end_err_evt,
   input  wire        nt_far_end_err_evt,
   // Snapshot indication
   output wire        snapshot_taken
);

   // --------------------------------------------
   // Counter numbering
   // --------------------------------------------
   localparam NCNT = 9;
   localparam C_CRC4   = 0;
   localparam C_FRAME  = 1;
   localparam C_ALIGN  = 2;
   localparam C_SYNC   = 3;
   localparam C_PATT   = 4;
   localparam C_LCODE  = 5;
   localparam C_NTCRC  = 6;
   localparam C_FAR_END_ERROR_COUNT   = 7;
   localparam C_NTFEBE = 8;

   // --------------------------------------------
   // Functions
   // --------------------------------------------
   // Saturation ceiling per counter
   function [15:0] esn_max;
      input integer idx;
      begin
         case (idx)
            C_FRAME:
               esn_max = `ESN_MAX_12;
            C_ALIGN:
               esn_max = `ESN_MAX_3;
            C_SYNC:
               esn_max = `ESN_MAX_5;
            C_PATT, C_LCODE:
               esn_max = `ESN_MAX_16;
            default:
               esn_max = `ESN_MAX_10;
         endcase
      end
   endfunction

   // Upper two bits of a 10-bit count sit in bits 5:4
   function [7:0] esn_hi10;
      input [15:0] v;
      begin
         esn_hi10 = {2'h0, v[9:8], 4'h0};
      end
   endfunction

   // --------------------------------------------
   // Registers
   // --------------------------------------------
   reg  [15:0] acc_q  [0:NCNT-1];
   reg  [15:0] snap_q [0:NCNT-1];
   reg         auto_en_q;
   reg         trig_q;
   reg         trig_prev_q;
   reg         hdb3_q;
   reg  [31:0] sec_cnt_q;
   reg         snap_done_q;
   reg  [7:0]  snap_seq_q;
   reg         wr_pend_q;
   reg  [7:0]  wr_idx_q;
   reg  [31:0] rdata_q;
   reg  [7:0]  rd_byte;
   reg  [NCNT-1:0] evt;
   reg         auto_en_d;
   reg         trig_d;
   reg         hdb3_d;
   reg  [31:0] sec_cnt_d;
   reg  [7:0]  snap_seq_d;
   reg  [31:0] rdata_d;
   integer     i;

   wire        addr_ph;
   wire [7:0]  a_idx;
   wire        trig_rise;
   wire        sec_tick;
   wire        snap;
   wire        lc_evt;
   wire        ctrl_wr;

   // --------------------------------------------
   // Event selection
   // --------------------------------------------
   assign lc_evt = hdb3_q ? code_viol_evt : bipolar_viol_evt;

   always @*
   begin
      evt           = {NCNT{1'b0}};
      evt[C_CRC4]   = crc4_err_evt;
      evt[C_FRAME]  = frame_err_evt;
      evt[C_ALIGN]  = align_change_evt;
      evt[C_SYNC]   = sync_loss_evt;
      evt[C_PATT]   = pattern_err_evt;
      evt[C_LCODE]  = lc_evt;
      evt[C_NTCRC]  = nt_crc_err_evt;
      evt[C_FAR_END_ERROR_COUNT]   = far_end_err_evt;
      evt[C_NTFEBE] = nt_far_end_err_evt;
   end

   // --------------------------------------------
   // Snapshot sources
   // --------------------------------------------
   assign trig_rise = trig_q & ~trig_prev_q;
   assign sec_tick  = auto_en_q &&
                      (sec_cnt_q == SNAP_PERIOD_CYC - 1);
   // One shared strobe keeps every count on the same interval
   assign snap      = trig_rise | sec_tick;

   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         trig_prev_q <= 1'b0;
      end
      else
      begin
         trig_prev_q <= trig_q;
      end
   end

   // Second timer only runs while auto snapshot is on
   // Enable pulse from a divider, not a second clock
   always @*
   begin
      if (!auto_en_q || sec_tick)
      begin
         sec_cnt_d = 32'h0;
      end
      else
      begin
         sec_cnt_d = sec_cnt_q + 32'h1;
      end
   end

   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         sec_cnt_q <= 32'h0;
      end
      else
      begin
         sec_cnt_q <= sec_cnt_d;
      end
   end

   // --------------------------------------------
   // Accumulators and snapshots
   // --------------------------------------------
   // An event in the snapshot cycle opens the new interval
   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         for (i = 0; i < NCNT; i = i + 1)
         begin
            acc_q[i]  <= 16'h0;
            snap_q[i] <= 16'h0;
         end
      end
      else
      begin
         for (i = 0; i < NCNT; i = i + 1)
         begin
            if (snap)
            begin
               snap_q[i] <= acc_q[i];
               acc_q[i]  <= {15'h0, evt[i]};
            end
            else if (evt[i] && acc_q[i] != esn_max(i))
            begin
               acc_q[i] <= acc_q[i] + 16'h1;
            end
         end
      end
   end

   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         snap_done_q <= 1'b0;
         snap_seq_q  <= 8'h0;
      end
      else
      begin
         snap_done_q <= snap;
         snap_seq_q  <= snap_seq_d;
      end
   end

   // Wraps; software compares two reads to spot a missed snapshot
   always @*
   begin
      snap_seq_d = snap_seq_q;
      if (snap)
      begin
         snap_seq_d = snap_seq_q + 8'h1;
      end
   end

   assign snapshot_taken = snap_done_q;

   // --------------------------------------------
   // Read decode
   // --------------------------------------------
   always @*
   begin
      case (a_idx)
         `ESN_IDX_CRC4_LO:
            rd_byte = snap_q[C_CRC4][7:0];
         `ESN_IDX_CRC4_HI:
            rd_byte = esn_hi10(snap_q[C_CRC4]);
         `ESN_IDX_FRAME_LO:
            rd_byte = snap_q[C_FRAME][7:0];
         `ESN_IDX_FRAME_HI:
            rd_byte = {4'h0, snap_q[C_FRAME][11:8]};
         `ESN_IDX_ALIGN:
            rd_byte = {5'h0, snap_q[C_ALIGN][2:0]};
         `ESN_IDX_SYNC:
            rd_byte = {3'h0, snap_q[C_SYNC][4:0]};
         `ESN_IDX_PATT_LO:
            rd_byte = snap_q[C_PATT][7:0];
         `ESN_IDX_PATT_HI:
            rd_byte = snap_q[C_PATT][15:8];
         `ESN_IDX_LCODE_LO:
            rd_byte = snap_q[C_LCODE][7:0];
         `ESN_IDX_LCODE_HI:
            rd_byte = snap_q[C_LCODE][15:8];
         `ESN_IDX_NTCRC_LO:
            rd_byte = snap_q[C_NTCRC][7:0];
         `ESN_IDX_NTCRC_HI:
            rd_byte = esn_hi10(snap_q[C_NTCRC]);
         `ESN_IDX_FAR_END_ERROR_COUNT_LO:
            rd_byte = snap_q[C_FAR_END_ERROR_COUNT][7:0];
         `ESN_IDX_FAR_END_ERROR_COUNT_HI:
            rd_byte = esn_hi10(snap_q[C_FAR_END_ERROR_COUNT]);
         `ESN_IDX_NTFEBE_LO:
            rd_byte = snap_q[C_NTFEBE][7:0];
         `ESN_IDX_NTFEBE_HI:
            rd_byte = esn_hi10(snap_q[C_NTFEBE]);
         `ESN_IDX_CTRL:
            rd_byte = {5'h0, hdb3_q, trig_q, auto_en_q};
         `ESN_IDX_STAT:
            rd_byte = snap_seq_q;
         default:
            rd_byte = 8'h00;
      endcase
   end

   // --------------------------------------------
   // AHB-Lite slave
   // --------------------------------------------
   // Zero wait states: read data is sampled at the address edge,
   // so a snapshot in that same cycle is seen on the next read.
   assign addr_ph   = hsel & htrans[1] & hready;
   assign a_idx     = (haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0)
                      ? haddr[9:2] : 8'hff;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 8'h0;
         rdata_q   <= 32'h0;
      end
      else
      begin
         wr_pend_q <= addr_ph & hwrite;
         if (addr_ph)
         begin
            wr_idx_q <= a_idx;
         end
         rdata_q <= rdata_d;
      end
   end

   // Captured once, so it stands through the data phase
   always @*
   begin
      rdata_d = rdata_q;
      if (addr_ph && !hwrite)
      begin
         rdata_d = {24'h0, rd_byte};
      end
   end

   // --------------------------------------------
   // Control register
   // --------------------------------------------
   // Control writes land at the end of the data phase
   assign ctrl_wr = wr_pend_q && (wr_idx_q == `ESN_IDX_CTRL);

   // Trigger bit is a level; only its rise fires a snapshot
   always @*
   begin
      auto_en_d = auto_en_q;
      trig_d    = trig_q;
      hdb3_d    = hdb3_q;
      if (ctrl_wr)
      begin
         auto_en_d = hwdata[`ESN_CTRL_AUTO_BIT];
         trig_d    = hwdata[`ESN_CTRL_TRIG_BIT];
         hdb3_d    = hwdata[`ESN_CTRL_HDB3_BIT];
      end
   end

   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         {hdb3_q, trig_q, auto_en_q} <= `ESN_CTRL_RESET;
      end
      else
      begin
         auto_en_q <= auto_en_d;
         trig_q    <= trig_d;
         hdb3_q    <= hdb3_d;
      end
   end

endmodule

// ==== tb/esn_error_snapshot_sva.sv ====
`timescale 1ns/10ps
module esn_error_snapshot_sva
#(
   parameter SNAP_PERIOD_CYC = 50
)
(
   // Clock and reset
   input wire        clk_sys,
   input wire        srst,
   // Register bus
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire [31:0] hwdata,
   input wire        hready,
   input wire [31:0] hrdata,
   // Snapshot indication
   input wire        snapshot_taken
);
   reg        ad_q;
   reg        wr_q;
   reg [7:0]  idx_q;
   reg        trig_q;
   reg        auto_q;
   reg        seen_q;
   reg [3:0]  rise_q;
   reg [31:0] gap_q;
   wire       ctl_wr = ad_q & wr_q & (idx_q == 8'h10);

   always @(posedge clk_sys)
   begin
      if (srst)
      begin
         {ad_q, wr_q, idx_q, trig_q, auto_q, seen_q, rise_q, gap_q} <= 'h0;
      end
      else
      begin
         ad_q   <= hsel & htrans[1] & hready;
         wr_q   <= hwrite;
         idx_q  <= haddr[9:2];
         trig_q <= ctl_wr ? hwdata[1] : trig_q;
         auto_q <= ctl_wr ? hwdata[0] : auto_q;
         rise_q <= {rise_q[2:0], ctl_wr & hwdata[1] & ~trig_q};
         gap_q  <= snapshot_taken ? 32'h0 : gap_q + 32'h1;
         seen_q <= auto_q & (seen_q | snapshot_taken);
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   sequence s_ctl_rise;
      (hsel && htrans[1] && hready && hwrite && haddr[9:2] == 8'h10) ##1 (hwdata[1] && !trig_q);
   endsequence
   property p_rd_mask(bit [7:0] i, bit [31:0] m);
      ad_q && !wr_q && idx_q == i |-> (hrdata & m) == 32'h0;
   endproperty

   a_trig_snap: assert property (s_ctl_rise |-> ##[1:3] snapshot_taken)
      else $error("no snapshot after trigger rise");
   a_snap_cause: assert property (snapshot_taken |-> auto_q || $past(auto_q) || rise_q != 4'h0)
      else $error("snapshot without a cause");
   a_snap_once: assert property (snapshot_taken |=> !snapshot_taken)
      else $error("snapshot pulse longer than one cycle");
   a_auto_period: assert property (seen_q |-> gap_q < SNAP_PERIOD_CYC && (!snapshot_taken || gap_q == SNAP_PERIOD_CYC - 1))
      else $error("auto snapshot period wrong");
   a_crc4_hi: assert property (p_rd_mask(8'h01, 32'hffffffcf))
      else $error("crc4 high bits misplaced");
   a_frame_hi: assert property (p_rd_mask(8'h03, 32'hfffffff0))
      else $error("frame high bits misplaced");
   a_align_width: assert property (p_rd_mask(8'h04, 32'hfffffff8))
      else $error("alignment count too wide");
   a_sync_width: assert property (p_rd_mask(8'h05, 32'hffffffe0))
      else $error("sync loss count too wide");
   a_ntcrc_hi: assert property (p_rd_mask(8'h0b, 32'hffffffcf))
      else $error("nt crc high bits misplaced");
   a_far_end_hi: assert property (p_rd_mask(8'h0d, 32'hffffffcf))
      else $error("far end high bits misplaced");
   a_nt_far_hi: assert property (p_rd_mask(8'h0f, 32'hffffffcf))
      else $error("nt far end high bits misplaced");
endmodule

bind esn_error_snapshot esn_error_snapshot_sva #(.SNAP_PERIOD_CYC(SNAP_PERIOD_CYC)) u_sva (
   .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .snapshot_taken(snapshot_taken));

// ==== tb/test_e1_error_counter_snapshot.sv ====
`timescale 1ns/10ps
`include "esn_defs.vh"
module test_e1_error_counter_snapshot;
   localparam int P = 50;
   reg          clk_sys;
   reg          srst;
   reg          hsel;
   reg   [31:0] haddr;
   reg   [1:0]  htrans;
   reg          hwrite;
   reg   [31:0] hwdata;
   reg   [9:0]  evt;
   wire         hready;
   wire  [31:0] hrdata;
   wire         snapshot_taken;
   wire         hresp;
   integer      n_mismatch;
   integer      cmp_count;
   integer      i;
   integer      k;
   reg   [31:0] rd;
   reg   [9:0]  m;
   reg   [11:0] n;
   reg          sel;
   reg   [7:0]  ix;
   reg   [7:0]  hx;
   reg   [7:0]  lo;
   reg   [7:0]  hi;
   // Events, count, line code select, indices, expected bytes
   reg   [54:0] rows [0:14];

   esn_error_snapshot #(.SNAP_PERIOD_CYC(P)) u_dut (
      .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .crc4_err_evt(evt[0]), .frame_err_evt(evt[1]), .align_change_evt(evt[2]), .sync_loss_evt(evt[3]),
      .pattern_err_evt(evt[4]), .bipolar_viol_evt(evt[5]), .code_viol_evt(evt[6]),
      .nt_crc_err_evt(evt[7]), .far_end_err_evt(evt[8]), .nt_far_end_err_evt(evt[9]),
      .snapshot_taken(snapshot_taken));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp)
         begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
         end
      end
   endtask

   task give_verdict;
      begin
         if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask

   task bus(input [7:0] idx, input wr, input [31:0] wd);
      begin
         hsel <= 1'b1;
         htrans <= 2'b10;
         haddr <= {22'h0, idx, 2'b00};
         hwrite <= wr;
         @(posedge clk_sys);
         while (hready !== 1'b1)
            @(posedge clk_sys);
         htrans <= 2'b00;
         hwdata <= wd;
         @(posedge clk_sys);
         while (hready !== 1'b1)
            @(posedge clk_sys);
         rd = hrdata;
      end
   endtask

   task wait_snap;
      integer t;
      begin
         for (t = 0; snapshot_taken !== 1'b1 && t < 64; t = t + 1)
            @(posedge clk_sys);
         chk({31'h0, t < 64}, 32'h1);
      end
   endtask

   task snap(input s);
      begin
         bus(`ESN_IDX_CTRL, 1'b1, {29'h0, s, 2'b10});
         wait_snap;
         bus(`ESN_IDX_CTRL, 1'b1, {29'h0, s, 2'b00});
      end
   endtask

   task pulse(input [9:0] msk, input [11:0] cnt);
      begin
         repeat (cnt)
         begin
            evt <= msk;
            @(posedge clk_sys);
         end
         evt <= 10'h0;
      end
   endtask

   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch = n_mismatch + 1;
      give_verdict;
   end

   initial
   begin
      {srst, hsel, haddr, htrans, hwrite, hwdata, evt} = {1'b1, 78'h0};
      n_mismatch = 0;
      cmp_count = 0;
      rows[0] = {10'h001, 12'h105, 1'b0, 8'h00, 8'h01, 8'h05, 8'h10};
      rows[1] = {10'h002, 12'h123, 1'b0, 8'h02, 8'h03, 8'h23, 8'h01};
      rows[2] = {10'h004, 12'h005, 1'b0, 8'h04, 8'h04, 8'h05, 8'h05};
      rows[3] = {10'h008, 12'h011, 1'b0, 8'h05, 8'h05, 8'h11, 8'h11};
      rows[4] = {10'h010, 12'h203, 1'b0, 8'h06, 8'h07, 8'h03, 8'h02};
      rows[5] = {10'h020, 12'h102, 1'b0, 8'h08, 8'h09, 8'h02, 8'h01};
      rows[6] = {10'h040, 12'h104, 1'b1, 8'h08, 8'h09, 8'h04, 8'h01};
      rows[7] = {10'h020, 12'h007, 1'b1, 8'h08, 8'h09, 8'h00, 8'h00};
      rows[8] = {10'h040, 12'h003, 1'b0, 8'h08, 8'h09, 8'h00, 8'h00};
      rows[9] = {10'h080, 12'h201, 1'b0, 8'h0a, 8'h0b, 8'h01, 8'h20};
      rows[10] = {10'h100, 12'h302, 1'b0, 8'h0c, 8'h0d, 8'h02, 8'h30};
      rows[11] = {10'h200, 12'h3ff, 1'b0, 8'h0e, 8'h0f, 8'hff, 8'h30};
      rows[12] = {10'h004, 12'h009, 1'b0, 8'h04, 8'h04, 8'h07, 8'h07};
      rows[13] = {10'h008, 12'h028, 1'b0, 8'h05, 8'h05, 8'h1f, 8'h1f};
      rows[14] = {10'h001, 12'h405, 1'b0, 8'h00, 8'h01, 8'hff, 8'h30};
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      // Write to a read-only place must not stick
      bus(8'h00, 1'b1, 32'hff);
      for (i = 0; i < 19; i = i + 1)
      begin
         bus(i == 18 ? 8'h20 : i[7:0], 1'b0, 32'h0);
         chk(rd, 32'h0);
         chk({30'h0, hresp, hready}, 32'h1);
      end
      for (i = 0; i < 15; i = i + 1)
      begin
         {m, n, sel, ix, hx, lo, hi} = rows[i];
         bus(`ESN_IDX_CTRL, 1'b1, {29'h0, sel, 2'b00});
         pulse(m, n);
         snap(sel);
         bus(ix, 1'b0, 32'h0);
         chk(rd, {24'h0, lo});
         bus(hx, 1'b0, 32'h0);
         chk(rd, {24'h0, hi});
      end
      pulse(10'h3ff, 12'h3);
      snap(1'b0);
      for (i = 0; i < 16; i = i + 1)
      begin
         bus(i[7:0], 1'b0, 32'h0);
         chk(rd, (i % 2 == 0 || i == 5) ? 32'h3 : 32'h0);
      end
      snap(1'b0);
      bus(8'h00, 1'b0, 32'h0);
      chk(rd, 32'h0);
      // Writing one over one is no rising change
      k = 0;
      bus(`ESN_IDX_CTRL, 1'b1, 32'h2);
      wait_snap;
      bus(`ESN_IDX_CTRL, 1'b1, 32'h2);
      repeat (8)
      begin
         @(posedge clk_sys);
         k = k + snapshot_taken;
      end
      chk(k, 32'h0);
      bus(`ESN_IDX_CTRL, 1'b1, 32'h1);
      wait_snap;
      pulse(10'h001, 12'h4);
      wait_snap;
      bus(8'h00, 1'b0, 32'h0);
      chk(rd, 32'h4);
      bus(`ESN_IDX_CTRL, 1'b1, 32'h0);
      pulse(10'h001, 12'h5);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      chk(hrdata, 32'h0);
      chk({31'h0, snapshot_taken}, 32'h0);
      bus(8'h00, 1'b0, 32'h0);
      chk(rd, 32'h0);
      snap(1'b0);
      bus(8'h00, 1'b0, 32'h0);
      chk(rd, 32'h0);
      bus(`ESN_IDX_STAT, 1'b0, 32'h0);
      chk(rd, 32'h1);
      give_verdict;
   end
endmodule
